// ==== hdl/cmc_pkg.sv ====
// Shared constants, types and helpers for the CAN mode controller and FIFO index block
package cmc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int FIFO_COUNT = 32;
  localparam int IDX_W = 5;
  localparam int MASK_COUNT = 4;

  // Global register index is addr[7:4] with addr[11:8] zero
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_INT = 4'h1;
  localparam logic [3:0] REG_CFG = 4'h2;
  localparam logic [3:0] REG_BASE = 4'h3;
  localparam logic [1:0] REG_MASK_GRP = 2'h1;
  // Per-FIFO block: addr[11] set, FIFO number addr[10:6], register addr[5:4]
  localparam logic [1:0] FREG_CON = 2'h0;
  localparam logic [1:0] FREG_UA = 2'h1;
  localparam logic [1:0] FREG_CI = 2'h2;
  // Alias selector addr[3:2]: 0x0 plain, 0x4 clear, 0x8 set, 0xc invert
  localparam logic [1:0] SUB_WR = 2'h0;
  localparam logic [1:0] SUB_CLR = 2'h1;
  localparam logic [1:0] SUB_SET = 2'h2;
  localparam logic [1:0] SUB_INV = 2'h3;

  localparam int CTRL_REQ_LSB = 24;
  localparam int CTRL_MODE_LSB = 21;
  localparam int CTRL_ON_BIT = 15;
  localparam int CTRL_BUSY_BIT = 11;
  localparam int INT_MODE_CHANGE_IRQ_ENABLE_BIT = 19;
  localparam int INT_MODIF_BIT = 3;
  localparam int FCON_DEPTH_LSB = 16;
  localparam int FCON_UINC_BIT = 13;
  localparam int FCON_DIR_BIT = 7;
  localparam int FCON_DATA_ONLY_RECEIVE_BIT = 6;

  localparam logic [2:0] BUF_SHIFT_FULL = 3'h4;
  localparam logic [2:0] BUF_SHIFT_DATA_ONLY_RECEIVE = 3'h3;
  localparam logic [2:0] DRAIN_CYCLES = 3'h4;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_DISABLE = 3'h1,
    MODE_LOOPBACK = 3'h2,
    MODE_LISTEN_ONLY = 3'h3,
    MODE_CONFIG = 3'h4,
    MODE_LISTEN_ALL = 3'h7
  } cmc_mode_t;

  typedef enum logic [1:0] {
    PWR_OFF = 2'h0,
    PWR_ACTIVE = 2'h1,
    PWR_DRAIN = 2'h3
  } cmc_pwr_t;

  function automatic logic [31:0] cmc_alias(input logic [31:0] cur, input logic [31:0] wd,
                                            input logic [1:0] sub);
    case (sub)
      SUB_CLR: return cur & ~wd;
      SUB_SET: return cur | wd;
      SUB_INV: return cur ^ wd;
      default: return wd;
    endcase
  endfunction : cmc_alias

  function automatic logic cmc_mode_ok(input logic [2:0] code);
    case (code)
      MODE_NORMAL, MODE_DISABLE, MODE_LOOPBACK, MODE_LISTEN_ONLY, MODE_CONFIG,
      MODE_LISTEN_ALL: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : cmc_mode_ok
endpackage : cmc_pkg

// ==== hdl/cmc_fifo_slot.sv ====
// User-side and controller-side index counters of one message FIFO
`timescale 1ns/1ps
`default_nettype none
module cmc_fifo_slot
  import cmc_pkg::*;
#(
  parameter int IDX_WIDTH = IDX_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hold,
  input wire logic [IDX_WIDTH-1:0] depthM1,
  input wire logic ctlStep,
  input wire logic userStep,
  output logic [IDX_WIDTH-1:0] ctlIndex,
  output logic [IDX_WIDTH-1:0] userIndex
);
  if (IDX_WIDTH < 1 || IDX_WIDTH > IDX_W) begin : g_bad_width
    $error("cmc_fifo_slot: IDX_WIDTH out of range");
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctlIndex <= '0;
    end else if (hold) begin
      ctlIndex <= '0;
    end else if (ctlStep) begin
      ctlIndex <= (ctlIndex >= depthM1) ? '0 : ctlIndex + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      userIndex <= '0;
    end else if (hold) begin
      userIndex <= '0;
    end else if (userStep) begin
      userIndex <= (userIndex >= depthM1) ? '0 : userIndex + 1'b1;
    end
  end

  chk_ctl_index_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    (ctlStep && !hold && ctlIndex == depthM1) |=> ctlIndex == '0)
    else $error("controller index did not wrap at fifo depth");
  chk_user_index_step: assert property (@(posedge clk_sys) disable iff (rst)
    (userStep && !hold && userIndex < depthM1) |=> userIndex == $past(userIndex) + 1'b1)
    else $error("user index did not advance by one");
  chk_hold_clears: assert property (@(posedge clk_sys) disable iff (rst)
    hold |=> (ctlIndex == '0 && userIndex == '0))
    else $error("fifo indexes not cleared while held");
endmodule : cmc_fifo_slot
`default_nettype wire

// ==== hdl/cmc_mode_fifo_ctrl.sv ====
// Operating-mode controller, enable sequencing and per-FIFO index registers of a CAN node
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cmc_mode_fifo_ctrl
  import cmc_pkg::*;
#(
  parameter int FIFO_N = FIFO_COUNT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdData,
  input wire logic engFrameActive,
  input wire logic [IDX_W-1:0] engFifoSel,
  input wire logic engTxDone,
  input wire logic engRxStored,
  input wire logic engTxBit,
  output logic engRunning,
  output logic engClkEn,
  output logic engTxAllowed,
  output logic engAckEnable,
  output logic engErrCntHold,
  output logic engErrCntClear,
  output logic engStoreErroneous,
  output logic engSelfAck,
  output logic engRxBit,
  output logic engFifoIsTx,
  output logic [31:0] engBufAddr,
  output logic [31:0] cfgBitTiming,
  output logic [31:0] acceptMask0,
  output logic [31:0] acceptMask1,
  output logic [31:0] acceptMask2,
  output logic [31:0] acceptMask3,
  output logic canIrq,
  input wire logic rxPin,
  output logic txPinOut,
  output logic txPinOe,
  output logic rxPinOwn
);
  if (FIFO_N < 1 || FIFO_N > FIFO_COUNT) begin : g_bad_fifo_n
    $error("cmc_mode_fifo_ctrl: FIFO_N must be 1 to 32");
  end

  cmc_pwr_t pwr;
  cmc_mode_t current_operating_mode;
  logic [2:0] requested_operating_mode;
  logic ctrlOn;
  logic [2:0] drainCnt;
  logic modeApplied;
  logic mode_change_irq_enable;
  logic modif;
  logic [31:0] fifoBase;
  logic [31:0] acceptMask [MASK_COUNT];
  logic rxMeta;
  logic rxSync;
  logic [31:0] rdNext;
  logic running;
  logic cfgMode;
  logic modeTx;
  logic modeRx;
  logic [31:0] ctrlView;
  logic [31:0] intView;
  logic [31:0] gNew;

  logic [IDX_W-1:0] fifoDepth [FIFO_N];
  logic fifoDir [FIFO_N];
  logic fifoDonly [FIFO_N];
  logic [IDX_W-1:0] ctlIdx [FIFO_N];
  logic [IDX_W-1:0] userIdx [FIFO_N];
  logic [2:0] bufShift [FIFO_N];
  logic [31:0] conView [FIFO_N];
  logic [31:0] uaAddr [FIFO_N];
  logic [15:0] prefix [FIFO_N+1];

  wire logic [1:0] sub = regAddr[3:2];
  wire logic [3:0] gIdx = regAddr[7:4];
  wire logic [IDX_W-1:0] fIdx = regAddr[10:6];
  wire logic [1:0] fReg = regAddr[5:4];
  wire logic isGlobal = !regAddr[11] && regAddr[10:8] == 3'h0;
  wire logic fOk = regAddr[11] && 32'(fIdx) < FIFO_N;
  wire logic selOk = 32'(engFifoSel) < FIFO_N;
  wire logic gWr = regWrite && isGlobal;

  assign running = (pwr == PWR_ACTIVE);
  assign cfgMode = (current_operating_mode == MODE_CONFIG);
  assign modeTx = running && (current_operating_mode == MODE_NORMAL || current_operating_mode == MODE_LISTEN_ALL ||
                              current_operating_mode == MODE_LOOPBACK);
  assign modeRx = modeTx || (running && current_operating_mode == MODE_LISTEN_ONLY);
  assign ctrlView = (32'(requested_operating_mode) << CTRL_REQ_LSB) | (32'(current_operating_mode) << CTRL_MODE_LSB) |
                    (32'(ctrlOn) << CTRL_ON_BIT) | (32'(pwr != PWR_OFF) << CTRL_BUSY_BIT);
  assign intView = (32'(mode_change_irq_enable) << INT_MODE_CHANGE_IRQ_ENABLE_BIT) | (32'(modif) << INT_MODIF_BIT);
  assign gNew = cmc_alias((gIdx == REG_INT) ? intView : ctrlView, regWrData, sub);

  // Engine strap outputs follow the power state and the reported mode, never the request
  assign engRunning = running;
  assign engTxAllowed = modeTx;
  assign engAckEnable = modeTx;
  assign engErrCntHold = (current_operating_mode == MODE_LISTEN_ONLY) || (current_operating_mode == MODE_DISABLE);
  assign engErrCntClear = !running || cfgMode;
  assign engStoreErroneous = running && (current_operating_mode == MODE_LISTEN_ALL);
  assign engSelfAck = running && (current_operating_mode == MODE_LOOPBACK);
  assign engClkEn = running && !(current_operating_mode == MODE_DISABLE && !engFrameActive);
  assign txPinOe = running;
  assign rxPinOwn = running;
  assign canIrq = modif && mode_change_irq_enable;
  assign acceptMask0 = acceptMask[0];
  assign acceptMask1 = acceptMask[1];
  assign acceptMask2 = acceptMask[2];
  assign acceptMask3 = acceptMask[3];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      requested_operating_mode <= MODE_CONFIG;
      ctrlOn <= 1'b0;
    end else if (gWr && gIdx == REG_CTRL) begin
      requested_operating_mode <= gNew[CTRL_REQ_LSB +: 3];
      ctrlOn <= gNew[CTRL_ON_BIT];
    end
  end

  // Switch-off drains for a few cycles so the engine sees its reset settle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwr <= PWR_OFF;
      drainCnt <= '0;
    end else begin
      case (pwr)
        PWR_OFF: begin
          if (ctrlOn) begin
            pwr <= PWR_ACTIVE;
          end
        end
        PWR_ACTIVE: begin
          if (!ctrlOn) begin
            pwr <= PWR_DRAIN;
            drainCnt <= DRAIN_CYCLES;
          end
        end
        PWR_DRAIN: begin
          if (drainCnt == 3'h1) begin
            pwr <= PWR_OFF;
          end
          drainCnt <= drainCnt - 3'h1;
        end
        default: pwr <= PWR_OFF;
      endcase
    end
  end

  // Requests apply only between frames, so a disable never cuts a frame short
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      current_operating_mode <= MODE_CONFIG;
      modeApplied <= 1'b0;
    end else begin
      modeApplied <= 1'b0;
      if (!running) begin
        current_operating_mode <= MODE_CONFIG;
      end else if (requested_operating_mode != current_operating_mode && cmc_mode_ok(requested_operating_mode) && !engFrameActive) begin
        current_operating_mode <= cmc_mode_t'(requested_operating_mode);
        modeApplied <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_change_irq_enable <= 1'b0;
      modif <= 1'b0;
    end else begin
      if (gWr && gIdx == REG_INT) begin
        mode_change_irq_enable <= gNew[INT_MODE_CHANGE_IRQ_ENABLE_BIT];
      end
      if (modeApplied) begin
        modif <= 1'b1;
      end else if (gWr && gIdx == REG_INT) begin
        modif <= gNew[INT_MODIF_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfgBitTiming <= '0;
      fifoBase <= '0;
      for (int i = 0; i < MASK_COUNT; i++) begin
        acceptMask[i] <= '0;
      end
    end else if (gWr && cfgMode) begin
      if (gIdx == REG_CFG) begin
        cfgBitTiming <= cmc_alias(cfgBitTiming, regWrData, sub);
      end
      if (gIdx == REG_BASE) begin
        fifoBase <= cmc_alias(fifoBase, regWrData, sub);
      end
      if (gIdx[3:2] == REG_MASK_GRP) begin
        acceptMask[gIdx[1:0]] <= cmc_alias(acceptMask[gIdx[1:0]], regWrData, sub);
      end
    end
  end

  for (genvar g = 0; g < FIFO_N; g++) begin : g_fifo
    logic conWr;
    logic [31:0] conNew;
    logic ctlStep;
    assign conWr = regWrite && fOk && fIdx == IDX_W'(g) && fReg == FREG_CON;
    assign conNew = cmc_alias(conView[g], regWrData, sub);
    assign conView[g] = (32'(fifoDepth[g]) << FCON_DEPTH_LSB) |
                        (32'(fifoDir[g]) << FCON_DIR_BIT) | (32'(fifoDonly[g]) << FCON_DATA_ONLY_RECEIVE_BIT);
    assign bufShift[g] = (!fifoDir[g] && fifoDonly[g]) ? BUF_SHIFT_DATA_ONLY_RECEIVE : BUF_SHIFT_FULL;
    assign prefix[g+1] = prefix[g] + ((16'(fifoDepth[g]) + 16'h1) << bufShift[g]);
    assign uaAddr[g] = fifoBase + 32'(prefix[g]) + (32'(userIdx[g]) << bufShift[g]);
    assign ctlStep = selOk && engFifoSel == IDX_W'(g) &&
                     ((engTxDone && fifoDir[g] && modeTx) ||
                      (engRxStored && !fifoDir[g] && modeRx));

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        fifoDepth[g] <= '0;
        fifoDir[g] <= 1'b0;
        fifoDonly[g] <= 1'b0;
      end else if (conWr) begin
        fifoDir[g] <= conNew[FCON_DIR_BIT];
        if (cfgMode) begin
          fifoDepth[g] <= conNew[FCON_DEPTH_LSB +: IDX_W];
          fifoDonly[g] <= conNew[FCON_DATA_ONLY_RECEIVE_BIT];
        end
      end
    end

    cmc_fifo_slot #(
      .IDX_WIDTH(IDX_W)
    ) u_slot (
      .clk_sys(clk_sys),
      .rst(rst),
      .hold(!running || cfgMode),
      .depthM1(fifoDepth[g]),
      .ctlStep(ctlStep),
      .userStep(conWr && conNew[FCON_UINC_BIT]),
      .ctlIndex(ctlIdx[g]),
      .userIndex(userIdx[g])
    );
  end
  assign prefix[0] = 16'h0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      engBufAddr <= '0;
      engFifoIsTx <= 1'b0;
    end else if (selOk) begin
      engBufAddr <= fifoBase + 32'(prefix[engFifoSel]) +
                    (32'(ctlIdx[engFifoSel]) << bufShift[engFifoSel]);
      engFifoIsTx <= fifoDir[engFifoSel];
    end else begin
      engBufAddr <= '0;
      engFifoIsTx <= 1'b0;
    end
  end

  // The bus pin is asynchronous; only the second stage feeds logic
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
    end else begin
      rxMeta <= rxPin;
      rxSync <= rxMeta;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txPinOut <= 1'b1;
      engRxBit <= 1'b1;
    end else begin
      engRxBit <= (running && current_operating_mode == MODE_LOOPBACK) ? engTxBit : rxSync;
      // Listen-only, loopback, disable and configuration all keep the pin recessive
      txPinOut <= (running && (current_operating_mode == MODE_NORMAL || current_operating_mode == MODE_LISTEN_ALL)) ?
                  engTxBit : 1'b1;
    end
  end

  always_comb begin
    rdNext = '0;
    if (sub == SUB_WR) begin
      if (isGlobal) begin
        case (gIdx)
          REG_CTRL: rdNext = ctrlView;
          REG_INT: rdNext = intView;
          REG_CFG: rdNext = cfgBitTiming;
          REG_BASE: rdNext = fifoBase;
          default: rdNext = (gIdx[3:2] == REG_MASK_GRP) ? acceptMask[gIdx[1:0]] : '0;
        endcase
      end else if (fOk) begin
        case (fReg)
          FREG_CON: rdNext = conView[fIdx];
          FREG_UA: rdNext = uaAddr[fIdx];
          FREG_CI: rdNext = 32'(ctlIdx[fIdx]);
          default: rdNext = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdData <= '0;
    end else begin
      regRdData <= regRead ? rdNext : '0;
    end
  end

  chk_index_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (regRead && regAddr[11] && regAddr[5:4] == FREG_CI) |=> regRdData[31:5] == '0)
    else $error("index register upper bits not zero");
  chk_off_config_mode: assert property (@(posedge clk_sys) disable iff (rst)
    (pwr == PWR_OFF) ##1 (pwr == PWR_OFF) |-> current_operating_mode == MODE_CONFIG && engErrCntClear)
    else $error("switched-off controller not in configuration mode");
  chk_off_pins_released: assert property (@(posedge clk_sys) disable iff (rst)
    (ctrlOn == 1'b0) |=> (!txPinOe && !rxPinOwn && !engRunning))
    else $error("pins still claimed after enable cleared");
  chk_on_claims_pins: assert property (@(posedge clk_sys) disable iff (rst)
    (pwr == PWR_OFF && ctrlOn) |=> (txPinOe && rxPinOwn))
    else $error("enable did not claim the pins");
  chk_busy_drain: assert property (@(posedge clk_sys) disable iff (rst)
    (pwr == PWR_ACTIVE && !ctrlOn) |=> ctrlView[CTRL_BUSY_BIT] [*4] ##1
    !ctrlView[CTRL_BUSY_BIT])
    else $error("busy status does not span the switch-off drain");
  chk_mode_waits_frame: assert property (@(posedge clk_sys) disable iff (rst)
    (running && engFrameActive) |=> (!running || current_operating_mode == $past(current_operating_mode)))
    else $error("mode changed during a frame");
  chk_mode_irq: assert property (@(posedge clk_sys) disable iff (rst)
    modeApplied |=> (modif && canIrq == mode_change_irq_enable))
    else $error("mode change interrupt missing");
  chk_disable_recessive: assert property (@(posedge clk_sys) disable iff (rst)
    (current_operating_mode == MODE_DISABLE) |=> txPinOut)
    else $error("transmit pin not recessive in disable mode");
  chk_loopback_path: assert property (@(posedge clk_sys) disable iff (rst)
    (running && current_operating_mode == MODE_LOOPBACK) |=> (engRxBit == $past(engTxBit) && txPinOut))
    else $error("loopback path wrong or bus driven");
  chk_cfg_locked: assert property (@(posedge clk_sys) disable iff (rst)
    (regWrite && isGlobal && gIdx == REG_CFG && !cfgMode) |=> $stable(cfgBitTiming))
    else $error("timing register written outside configuration");
  chk_listen_only_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    (current_operating_mode == MODE_LISTEN_ONLY) |-> (!engTxAllowed && !engAckEnable && engErrCntHold))
    else $error("listen-only mode not passive");
endmodule : cmc_mode_fifo_ctrl
`default_nettype wire

// ==== verification/cmc_bus_node_model.sv ====
// Far-side CAN nodes: wired-AND bus level seen at the controller's receive pin
`timescale 1ns/1ps
`default_nettype none
module cmc_bus_node_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic frameOn,
  input wire logic txPinOut,
  input wire logic txPinOe,
  output logic rxPin
);
  logic nodeBit;

  // Other nodes send a changing stream inside frames and stay recessive between them
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nodeBit <= 1'b1;
    end else begin
      nodeBit <= frameOn ? 1'($urandom_range(1)) : 1'b1;
    end
  end

  // Dominant wins; a released pin leaves the bus to the other nodes
  assign rxPin = nodeBit & (txPinOe ? txPinOut : 1'b1);
endmodule : cmc_bus_node_model
`default_nettype wire

// ==== verification/test_cmc_mode_fifo_ctrl.sv ====
// Self-checking bench for the CAN mode controller and FIFO index block
`timescale 1ns/1ps
`default_nettype none
module test_cmc_mode_fifo_ctrl;
  import cmc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWrData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic engFrameActive = 1'b0;
  logic [4:0] engFifoSel = 5'h00;
  logic engTxDone = 1'b0;
  logic engRxStored = 1'b0;
  logic engTxBit = 1'b0;
  logic [31:0] regRdData, engBufAddr;
  logic engClkEn, engTxAllowed, engErrCntHold, engStoreErroneous, engSelfAck, engRxBit;
  logic engFifoIsTx, canIrq, rxPin, txPinOut, txPinOe, rxPinOwn;
  logic engRunning, engAckEnable, engErrCntClear;
  logic [31:0] cfgBitTiming, acceptMask0, acceptMask1, acceptMask2, acceptMask3;
  logic [31:0] expQ[$];
  logic rdPend = 1'b0;
  logic [31:0] r1, base;
  int checks = 0;
  int failCount = 0;
  cmc_mode_t modeList[5] = '{MODE_LISTEN_ONLY, MODE_LISTEN_ALL, MODE_LOOPBACK, MODE_NORMAL,
                             MODE_DISABLE};

  always #4 clk_sys = ~clk_sys;

  cmc_mode_fifo_ctrl u_dut (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .engFrameActive(engFrameActive), .engFifoSel(engFifoSel), .engTxDone(engTxDone),
    .engRxStored(engRxStored), .engTxBit(engTxBit), .engRunning(engRunning),
    .engClkEn(engClkEn), .engTxAllowed(engTxAllowed), .engAckEnable(engAckEnable),
    .engErrCntHold(engErrCntHold), .engErrCntClear(engErrCntClear),
    .engStoreErroneous(engStoreErroneous), .engSelfAck(engSelfAck),
    .engRxBit(engRxBit), .engFifoIsTx(engFifoIsTx), .engBufAddr(engBufAddr),
    .cfgBitTiming(cfgBitTiming), .acceptMask0(acceptMask0), .acceptMask1(acceptMask1),
    .acceptMask2(acceptMask2), .acceptMask3(acceptMask3),
    .canIrq(canIrq), .rxPin(rxPin), .txPinOut(txPinOut), .txPinOe(txPinOe),
    .rxPinOwn(rxPinOwn)
  );

  cmc_bus_node_model u_node (
    .clk_sys(clk_sys), .rst(rst), .frameOn(engFrameActive), .txPinOut(txPinOut),
    .txPinOe(txPinOe), .rxPin(rxPin)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stopTest();
    $display("checks %0d errors %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stopTest

  // Read data stand only in the cycle after the strobe, so compare exactly there
  always @(posedge clk_sys) begin
    rdPend <= regRead;
    if (rdPend && expQ.size() > 0) begin
      check(regRdData, expQ.pop_front());
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    @(posedge clk_sys);
    regRead <= 1'b0;
  endtask : rd

  task automatic pulse(input logic [4:0] sel, input logic tx);
    @(posedge clk_sys);
    engFifoSel <= sel;
    engTxDone <= tx;
    engRxStored <= !tx;
    @(posedge clk_sys);
    engTxDone <= 1'b0;
    engRxStored <= 1'b0;
  endtask : pulse

  function automatic logic [31:0] ctrlView(input logic [2:0] rq, input logic [2:0] m);
    // Enable set, and busy stays up for as long as the controller is not fully off
    return (32'(rq) << 24) | (32'(m) << 21) | 32'h0000_8800;
  endfunction : ctrlView

  // Bus is idle, so the change lands one cycle after the write is taken and the flag one later
  task automatic setMode(input cmc_mode_t m);
    logic talks;
    talks = (m == MODE_NORMAL) || (m == MODE_LISTEN_ALL);
    wr(12'h000, (32'(m) << 24) | 32'h0000_8000);
    tick(3);
    check(canIrq, 1'b1);
    check(engTxAllowed, talks || (m == MODE_LOOPBACK));
    check(engAckEnable, talks || (m == MODE_LOOPBACK));
    check(engErrCntClear, 1'b0);
    check(engRunning, 1'b1);
    check(engErrCntHold, (m == MODE_LISTEN_ONLY) || (m == MODE_DISABLE));
    check(engStoreErroneous, m == MODE_LISTEN_ALL);
    check(engSelfAck, m == MODE_LOOPBACK);
    check(engClkEn, m != MODE_DISABLE);
    check(txPinOut, !talks);
    if (m == MODE_LOOPBACK) begin
      check(engRxBit, 1'b0);
    end
    rd(12'h000, ctrlView(m, m));
    wr(12'h014, 32'h0000_0008);
  endtask : setMode

  initial begin
    #100000;
    failCount++;
    stopTest();
  end

  initial begin
    void'($urandom(3));
    r1 = $urandom;
    base = $urandom & 32'hffff_fff0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(12'h000, 32'h0480_0000);
    check(txPinOe, 1'b0);
    check(engErrCntClear, 1'b1);
    wr(12'h000, 32'h0400_8000);
    tick(2);
    check(txPinOe, 1'b1);
    check(rxPinOwn, 1'b1);
    wr(12'h020, r1);
    wr(12'h028, 32'h0000_0001);
    rd(12'h020, r1 | 32'h1);
    wr(12'h030, base);
    wr(12'h050, ~r1);
    wr(12'h800, 32'h0003_0080);
    wr(12'h840, 32'h0001_0000);
    wr(12'h010, 32'h0008_0000);
    setMode(MODE_NORMAL);
    rd(12'h010, 32'h0008_0000);
    wr(12'h020, ~r1);
    wr(12'h050, r1);
    rd(12'h020, r1 | 32'h1);
    check(cfgBitTiming, r1 | 32'h1);
    check(acceptMask1, ~r1);
    check(acceptMask0 | acceptMask2 | acceptMask3, 32'h0);
    repeat (5) pulse(5'h00, 1'b1);
    repeat (3) pulse(5'h01, 1'b0);
    rd(12'h820, 32'h1);
    rd(12'h860, 32'h1);
    rd(12'h824, 32'h0);
    rd(12'h0f0, 32'h0);
    rd(12'h850, base + 32'h40);
    wr(12'h848, 32'h0000_2000);
    rd(12'h850, base + 32'h50);
    tick(2);
    check(engBufAddr, base + 32'h50);
    check(engFifoIsTx, 1'b0);
    foreach (modeList[i]) begin
      setMode(modeList[i]);
    end
    @(posedge clk_sys);
    engFrameActive <= 1'b1;
    tick(1);
    check(engClkEn, 1'b1);
    wr(12'h000, 32'h0400_8000);
    tick(4);
    rd(12'h000, ctrlView(3'h4, 3'h1));
    @(posedge clk_sys);
    engFrameActive <= 1'b0;
    tick(3);
    rd(12'h000, ctrlView(3'h4, 3'h4));
    wr(12'h000, 32'h0400_0000);
    rd(12'h000, 32'h0480_0800);
    check(txPinOe, 1'b0);
    tick(6);
    rd(12'h000, 32'h0480_0000);
    rd(12'h820, 32'h0);
    tick(3);
    stopTest();
  end
endmodule : test_cmc_mode_fifo_ctrl
`default_nettype wire
